// File: logic/pslc_decoder.sv
/*
  Combinational symbol decoder, the inverse of the encoder tables.
  Assumes bits above the symbol length are zero.
*/
module pslc_decoder import pslc_pkg::*; (
  input wire logic [1:0] mode,
  input wire logic [11:0] sym,
  output logic is_cmd,
  output logic [9:0] data,
  output logic [3:0] cmd,
  output logic violation
);
  function automatic logic [4:0] inv4(input logic [4:0] code);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (ENC4[i] == code) r = {1'b1, 4'(i)};
    end
    return r;
  endfunction : inv4

  function automatic logic [5:0] inv5(input logic [5:0] code);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < 32; i++) begin
      if (ENC5[i] == code) r = {1'b1, 5'(i)};
    end
    return r;
  endfunction : inv5

  logic [4:0] n_hi, n_lo;
  logic [5:0] f_hi, f_lo;
  logic hit;

  always_comb begin
    n_hi = inv4(sym[9:5]);
    n_lo = inv4(sym[4:0]);
    f_hi = inv5((mode == MODE9) ? sym[10:5] : sym[11:6]);
    f_lo = inv5(sym[5:0]);
    is_cmd = 1'b0;
    cmd = 4'h0;
    case (mode)
      MODE9: begin
        data = {1'b0, f_hi[4:0], n_lo[3:0]};
        hit = f_hi[5] && n_lo[4];
        for (int i = 1; i < 8; i++) begin
          if ({1'b0, CMD9[i]} == sym) begin
            is_cmd = 1'b1;
            cmd = {1'b0, 3'(i)};
          end
        end
        if (sym == SYNC9) is_cmd = 1'b1;
      end
      MODE10: begin
        data = {f_lo[4], f_hi[4:0], f_lo[3:0]};
        hit = f_hi[5] && f_lo[5];
        for (int i = 1; i < 4; i++) begin
          if (CMD10[i] == sym) begin
            is_cmd = 1'b1;
            cmd = {2'b00, 2'(i)};
          end
        end
        if (sym == SYNC10) is_cmd = 1'b1;
      end
      default: begin
        data = {2'b00, n_hi[3:0], n_lo[3:0]};
        hit = n_hi[4] && n_lo[4];
        for (int i = 1; i < 16; i++) begin
          if ({2'b00, CMD8[i]} == sym) begin
            is_cmd = 1'b1;
            cmd = 4'(i);
          end
        end
        if (sym == SYNC8) is_cmd = 1'b1;
      end
    endcase
    violation = !is_cmd && !hit;
  end
endmodule : pslc_decoder

// File: logic/pslc_encoder.sv
/*
  Combinational symbol encoder: data or command word to a right-aligned symbol.
  Assumes the command field is already masked to the width of the mode.
*/
module pslc_encoder import pslc_pkg::*; (
  input wire logic [1:0] mode,
  input wire logic [9:0] data,
  input wire logic [3:0] cmd,
  output logic [11:0] sym
);
  // No command code reaches a sync symbol
  always_comb begin
    sym = 12'h000;
    case (mode)
      MODE9: begin
        if (cmd[2:0] != 3'h0) sym = {1'b0, CMD9[cmd[2:0]]};
        else sym = {1'b0, ENC5[data[8:4]], ENC4[data[3:0]]};
      end
      MODE10: begin
        if (cmd[1:0] != 2'h0) sym = CMD10[cmd[1:0]];
        else sym = {ENC5[data[8:4]], ENC5[{data[9], data[3:0]}]};
      end
      default: begin
        if (cmd != 4'h0) sym = {2'b00, CMD8[cmd]};
        else sym = {2'b00, ENC4[data[7:4]], ENC4[data[3:0]]};
      end
    endcase
  end
endmodule : pslc_encoder

// File: logic/pslc_pkg.sv
/*
  Constants, code tables and register map of the parallel/serial link codec.
  Assumes one 100 MHz clock that serves as the serial bit clock.
*/
package pslc_pkg;
  localparam logic [1:0] MODE8 = 2'h0;
  localparam logic [1:0] MODE9 = 2'h1;
  localparam logic [1:0] MODE10 = 2'h2;
  localparam logic [3:0] LEN8 = 4'ha;
  localparam logic [3:0] LEN9 = 4'hb;
  localparam logic [3:0] LEN10 = 4'hc;
  localparam logic [3:0] HALF8 = 4'h5;
  localparam logic [3:0] HALF_WIDE = 4'h6;
  localparam logic [11:0] SYNC8 = 12'h311;
  localparam logic [11:0] SYNC9 = 12'h311;
  localparam logic [11:0] SYNC10 = 12'h623;
  localparam logic [5:0] SYNC_HI = 6'h18;
  localparam logic [3:0] CMD_MASK8 = 4'hf;
  localparam logic [3:0] CMD_MASK9 = 4'h7;
  localparam logic [3:0] CMD_MASK10 = 4'h3;
  localparam logic [4:0] ENC4 [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  localparam logic [5:0] ENC5 [32] = '{6'h36, 6'h11, 6'h24, 6'h25, 6'h12, 6'h13, 6'h16, 6'h17,
    6'h22, 6'h31, 6'h37, 6'h27, 6'h32, 6'h33, 6'h34, 6'h35,
    6'h3e, 6'h19, 6'h29, 6'h2d, 6'h1a, 6'h1b, 6'h1e, 6'h1f,
    6'h2a, 6'h2b, 6'h2e, 6'h2f, 6'h3a, 6'h3b, 6'h3c, 6'h3d};
  // Entry zero stands for data and is never looked up
  localparam logic [9:0] CMD8 [16] = '{10'h000, 10'h3ff, 10'h1ad, 10'h1b9, 10'h3e4, 10'h1a7,
    10'h327, 10'h339, 10'h084, 10'h09f, 10'h080, 10'h0e7, 10'h0f9, 10'h004, 10'h01f, 10'h000};
  localparam logic [10:0] CMD9 [8] = '{11'h000, 11'h7ff, 11'h3ad, 11'h3b9, 11'h7e4, 11'h3a7,
    11'h727, 11'h739};
  localparam logic [11:0] CMD10 [4] = '{12'h000, 12'hfff, 12'h75d, 12'h779};
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam int CTRL_MODE_LO = 0;
  localparam int CTRL_MODE_HI = 1;
  localparam int CTRL_LOCAL_BIT = 2;
  localparam logic [1:0] CTRL_MODE_RST = 2'h0;
  localparam logic CTRL_LOCAL_RST = 1'b1;
  localparam int ST_STAGE1 = 0;
  localparam int ST_STAGE2 = 1;
  localparam int ST_ENC = 2;
  localparam int ST_INSYNC = 3;
  localparam int ST_VIOL = 4;
  localparam int ST_WARN = 5;
endpackage : pslc_pkg

// File: logic/pslc_top.sv
/*
  Parallel/serial link codec: transmitter with two-stage input latch,
  encoder and shifter, receiver with byte sync, decoder and output latch,
  plus an Avalon-MM slave for mode and status.
  Assumes clk is the serial bit clock; the link pins are asynchronous to it, the Avalon-MM port is synchronous to it.
*/
// Register access over Avalon-MM and the register offsets are this design's own decisions.
module pslc_top import pslc_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic byte_reference_in,
  output logic tx_clk_out,
  input wire logic [9:0] tx_data_in,
  input wire logic [3:0] tx_cmd_in,
  input wire logic input_word_strobe,
  output logic tx_ack,
  output logic tx_busy,
  output logic serial_line_out,
  input wire logic serial_line_in,
  input wire logic cascade_next_byte_in,
  output logic rx_clk_out,
  output logic [9:0] rx_data_out,
  output logic [3:0] rx_cmd_out,
  output logic data_out_pulse,
  output logic command_out_pulse,
  output logic symbol_violation_flag,
  output logic early_word_warning
);
  logic [1:0] ctrl_mode;
  logic local_mode;
  logic [1:0] mode_sel;
  logic [3:0] sym_len, sym_last, half_len, cmd_mask;
  logic [11:0] sync_sym, len_mask;
  logic [5:0] half_mask;

  always_comb begin
    mode_sel = (ctrl_mode == MODE8 || ctrl_mode == MODE9 || ctrl_mode == MODE10) ?
      ctrl_mode : MODE8;
    case (mode_sel)
      MODE9: begin
        sym_len = LEN9;
        half_len = HALF_WIDE;
        sync_sym = SYNC9;
        cmd_mask = CMD_MASK9;
      end
      MODE10: begin
        sym_len = LEN10;
        half_len = HALF_WIDE;
        sync_sym = SYNC10;
        cmd_mask = CMD_MASK10;
      end
      default: begin
        sym_len = LEN8;
        half_len = HALF8;
        sync_sym = SYNC8;
        cmd_mask = CMD_MASK8;
      end
    endcase
    sym_last = sym_len - 4'h1;
    len_mask = ~(12'hfff << sym_len);
    half_mask = ~(6'h3f << half_len);
  end

  // Pin synchronisers; data travels with its strobe so both settle together
  logic [17:0] pin_s1, pin_s2;
  logic ref_s, cnb_s, ser_s, stb_s;
  logic [3:0] cmd_s;
  logic [9:0] dat_s;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 18'h00000;
      pin_s2 <= 18'h00000;
    end else begin
      pin_s1 <= {byte_reference_in, cascade_next_byte_in, serial_line_in,
        input_word_strobe, tx_cmd_in, tx_data_in};
      pin_s2 <= pin_s1;
    end
  end
  assign {ref_s, cnb_s, ser_s, stb_s, cmd_s, dat_s} = pin_s2;

  logic stb_q, cnb_q;
  logic strobe_evt, cnb_fall;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stb_q <= 1'b0;
      cnb_q <= 1'b1;
    end else begin
      stb_q <= stb_s;
      cnb_q <= cnb_s;
    end
  end
  assign strobe_evt = stb_s && !stb_q;
  assign cnb_fall = !cnb_s && cnb_q;

  // Local mode reference buffer; no PLL here, clk already is the bit rate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tx_clk_out <= 1'b0;
    else tx_clk_out <= local_mode && ref_s;
  end

  // Transmit bit counter; tick marks the internal byte boundary
  logic [3:0] tx_cnt, tx_bit_idx;
  logic tick;
  assign tick = (tx_cnt >= sym_last);
  assign tx_bit_idx = sym_last - tx_cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tx_cnt <= 4'h0;
    else if (tick) tx_cnt <= 4'h0;
    else tx_cnt <= tx_cnt + 4'h1;
  end

  // Two-stage input latch feeding the encoder latch
  logic s1_full, s2_full, enc_valid, direct;
  logic [13:0] s1_word, s2_word, enc_word, word_in;
  assign word_in = {cmd_s & cmd_mask, dat_s};
  assign direct = strobe_evt && (tick ? !s1_full : !s2_full);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_full <= 1'b0;
      s2_full <= 1'b0;
      enc_valid <= 1'b0;
      s1_word <= 14'h0000;
      s2_word <= 14'h0000;
      enc_word <= 14'h0000;
    end else if (tick) begin
      enc_valid <= s2_full;
      enc_word <= s2_word;
      if (s1_full) begin
        s2_word <= s1_word;
        s2_full <= 1'b1;
        s1_full <= strobe_evt;
        if (strobe_evt) s1_word <= word_in;
      end else begin
        s2_full <= strobe_evt;
        if (strobe_evt) s2_word <= word_in;
      end
    end else if (strobe_evt) begin
      if (!s2_full) begin
        s2_full <= 1'b1;
        s2_word <= word_in;
      end else begin
        // Unprotected: a later strobe replaces the held word
        s1_full <= 1'b1;
        s1_word <= word_in;
      end
    end
  end
  assign tx_busy = s1_full;

  // Acknowledge rises on acceptance into stage two, falls with the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tx_ack <= 1'b0;
    else if (direct || (tick && s1_full)) tx_ack <= 1'b1;
    else if (!stb_s) tx_ack <= 1'b0;
  end

  logic [11:0] enc_sym, tx_sh;
  pslc_encoder u_enc (
    .mode(mode_sel),
    .data(enc_word[9:0]),
    .cmd(enc_word[13:10]),
    .sym(enc_sym)
  );

  // Shifter fills with sync from the bit counter so idle bytes are sync
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tx_sh <= 12'h000;
    else if (tick && enc_valid) tx_sh <= enc_sym;
    else tx_sh <= {tx_sh[10:0], sync_sym[tx_bit_idx]};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) serial_line_out <= 1'b0;
    else serial_line_out <= tx_sh[sym_last];
  end

  // Receiver shifter and byte sync
  logic [11:0] rx_sh, dec_latch;
  logic [3:0] rx_cnt;
  logic sync_hit, rx_bnd, in_sync, dec_valid, out_evt;
  assign sync_hit = ((rx_sh & len_mask) == sync_sym);
  assign rx_bnd = sync_hit || (in_sync && rx_cnt >= sym_last);
  assign out_evt = dec_valid && (rx_bnd || cnb_fall);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rx_sh <= 12'h000;
    else rx_sh <= {rx_sh[10:0], ser_s};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_cnt <= 4'h0;
      in_sync <= 1'b0;
    end else begin
      if (sync_hit) in_sync <= 1'b1;
      if (rx_bnd) rx_cnt <= 4'h0;
      else rx_cnt <= rx_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_latch <= 12'h000;
      dec_valid <= 1'b0;
    end else if (rx_bnd) begin
      dec_latch <= rx_sh & len_mask;
      dec_valid <= 1'b1;
    end
  end

  // High for the first half of each received byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rx_clk_out <= 1'b0;
    else rx_clk_out <= in_sync && (rx_cnt < half_len);
  end

  logic d_is_cmd, d_viol;
  logic [9:0] d_data;
  logic [3:0] d_cmd;
  pslc_decoder u_dec (
    .mode(mode_sel),
    .sym(dec_latch),
    .is_cmd(d_is_cmd),
    .data(d_data),
    .cmd(d_cmd),
    .violation(d_viol)
  );

  // Output latch: one byte behind the decoder latch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_data_out <= 10'h000;
      rx_cmd_out <= 4'h0;
      symbol_violation_flag <= 1'b0;
    end else if (out_evt) begin
      symbol_violation_flag <= d_viol;
      if (d_is_cmd) rx_cmd_out <= d_cmd;
      else rx_data_out <= d_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out_pulse <= 1'b0;
      command_out_pulse <= 1'b0;
    end else begin
      data_out_pulse <= out_evt && !d_is_cmd;
      command_out_pulse <= out_evt && d_is_cmd;
    end
  end

  // Decided at mid-symbol, so it leads the output of that symbol
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) early_word_warning <= 1'b0;
    else if (!cnb_s) early_word_warning <= 1'b0;
    else if (in_sync && rx_cnt == half_len - 4'h1) begin
      early_word_warning <= ((rx_sh[5:0] & half_mask) != SYNC_HI);
    end
  end

  // Avalon-MM slave: one wait state, write at the release edge, read data captured one edge before it
  logic bus_ack, viol_sticky, viol_clr;
  logic [31:0] rd_word;
  assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;
  assign viol_clr = avs_write && bus_ack && avs_address == ADDR_STATUS &&
    avs_byteenable[0] && avs_writedata[ST_VIOL];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) bus_ack <= 1'b0;
    else bus_ack <= (avs_read || avs_write) && !bus_ack;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_mode <= CTRL_MODE_RST;
      local_mode <= CTRL_LOCAL_RST;
    end else if (avs_write && bus_ack && avs_address == ADDR_CTRL && avs_byteenable[0]) begin
      ctrl_mode <= avs_writedata[CTRL_MODE_HI:CTRL_MODE_LO];
      local_mode <= avs_writedata[CTRL_LOCAL_BIT];
    end
  end

  // A violation in the clearing cycle survives the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) viol_sticky <= 1'b0;
    else if (out_evt && d_viol) viol_sticky <= 1'b1;
    else if (viol_clr) viol_sticky <= 1'b0;
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    if (avs_address == ADDR_CTRL) begin
      rd_word[CTRL_MODE_HI:CTRL_MODE_LO] = ctrl_mode;
      rd_word[CTRL_LOCAL_BIT] = local_mode;
    end else if (avs_address == ADDR_STATUS) begin
      rd_word[ST_STAGE1] = s1_full;
      rd_word[ST_STAGE2] = s2_full;
      rd_word[ST_ENC] = enc_valid;
      rd_word[ST_INSYNC] = in_sync;
      rd_word[ST_VIOL] = viol_sticky;
      rd_word[ST_WARN] = early_word_warning;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) avs_readdata <= 32'h0000_0000;
    else if (avs_read && !bus_ack) avs_readdata <= rd_word;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_strobe_direct: assert property (
    strobe_evt && !s2_full && !tick |=> s2_full && s2_word == $past(word_in))
    else $error("strobe into empty latch missed stage two");

  a_stage_one_use: assert property (
    strobe_evt && s2_full && !tick |=> s1_full && $stable(s2_word))
    else $error("strobe with full stage two missed stage one");

  a_boundary_move: assert property (
    tick && s1_full |=> s2_full && s2_word == $past(s1_word) && enc_word == $past(s2_word))
    else $error("byte boundary did not advance latch stages");

  a_enc_latch_load: assert property (
    !tick |=> $stable(enc_word) && $stable(enc_valid))
    else $error("encoder latch changed off the byte boundary");

  a_shifter_load: assert property (
    tick && enc_valid |=> tx_sh == $past(enc_sym))
    else $error("shifter missed parallel load");

  a_byte_period8: assert property (
    (tick && mode_sel == MODE8) ##1 (mode_sel == MODE8 && !tick)[*8] ##1 mode_sel == MODE8
    ##1 mode_sel == MODE8 |-> tick && !$past(tick))
    else $error("8-bit mode byte is not ten bit clocks");

  a_sync_restart: assert property (
    sync_hit |=> rx_cnt == 4'h0 ##1 rx_cnt == 4'h1)
    else $error("sync did not restart receive bit counter");

  a_strobe_excl: assert property (
    !(data_out_pulse && command_out_pulse))
    else $error("data and command strobes together");

  a_data_keeps_cmd: assert property (
    data_out_pulse |-> rx_cmd_out == $past(rx_cmd_out))
    else $error("data transfer altered command outputs");

  a_cmd_keeps_data: assert property (
    command_out_pulse |-> rx_data_out == $past(rx_data_out))
    else $error("command transfer altered data outputs");

  a_warn_cascade: assert property (
    !cnb_s |=> !early_word_warning)
    else $error("warning stayed high with cascade input low");

  a_ack_follows: assert property (
    direct |=> tx_ack)
    else $error("acknowledge did not rise on direct accept");
endmodule : pslc_top

// File: sim/pslc_link_partner.sv
/*
  Far link end: loops the transmit line back, or sends bench-chosen bits.
  Assumes the bench changes inject_en and inject_bit just after rising edges.
*/
module pslc_link_partner (
  input wire logic clk,
  input wire logic tx_line,
  input wire logic inject_en,
  input wire logic inject_bit,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // Retimed so the line moves just after an edge, like a real far end
  always_ff @(posedge clk) begin
    rx_line <= inject_en ? inject_bit : tx_line;
  end
endmodule : pslc_link_partner

// File: sim/testbench.sv
/*
  Self-checking bench for the link codec: bus, idle sync, words, burst, receive faults.
  Assumes pslc_pkg and pslc_top are compiled first; serial out loops back via the partner.
*/
module testbench import pslc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [1:0] m; logic [3:0] c; logic [9:0] d; logic [11:0] s;} pslc_case_t;
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest, byte_reference_in, tx_clk_out;
  logic [3:0] avs_address, avs_byteenable, tx_cmd_in, rx_cmd_out;
  logic [31:0] avs_writedata, avs_readdata;
  logic [9:0] tx_data_in, rx_data_out;
  logic input_word_strobe, tx_ack, tx_busy, serial_line_out, serial_line_in;
  logic cascade_next_byte_in, rx_clk_out, data_out_pulse, command_out_pulse;
  logic symbol_violation_flag, early_word_warning, inject_en, inject_bit, viol_seen;
  logic [11:0] ser_sh;
  logic [9:0] dq [$];
  logic [3:0] cq [$];
  int mismatches, check_count, cyc;
  logic [11:0] sync_v [3] = '{12'h311, 12'h311, 12'h623};
  pslc_case_t tc [8] = '{'{2'h0, 4'h1, 10'h000, 12'h3ff}, '{2'h0, 4'h2, 10'h000, 12'h1ad},
    '{2'h0, 4'h0, 10'h0a5, 12'h2cb}, '{2'h1, 4'h2, 10'h000, 12'h3ad},
    '{2'h1, 4'h9, 10'h000, 12'h7ff}, '{2'h1, 4'h0, 10'h1ff, 12'h7bd},
    '{2'h2, 4'h1, 10'h000, 12'hfff}, '{2'h2, 4'h0, 10'h200, 12'hdbe}};

  pslc_top uut (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .byte_reference_in, .tx_clk_out,
    .tx_data_in, .tx_cmd_in, .input_word_strobe, .tx_ack, .tx_busy, .serial_line_out,
    .serial_line_in, .cascade_next_byte_in, .rx_clk_out, .rx_data_out, .rx_cmd_out,
    .data_out_pulse, .command_out_pulse, .symbol_violation_flag, .early_word_warning);
  pslc_link_partner link (.clk, .tx_line(serial_line_out), .inject_en, .inject_bit,
    .rx_line(serial_line_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    ser_sh <= {ser_sh[10:0], serial_line_out};
    if (data_out_pulse === 1'b1) dq.push_back(rx_data_out);
    if (command_out_pulse === 1'b1 && rx_cmd_out !== 4'h0) cq.push_back(rx_cmd_out);
    if ((data_out_pulse | command_out_pulse) === 1'b1 && symbol_violation_flag === 1'b1)
      viol_seen <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check

  task finish_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, input logic [3:0] be,
      output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0 && ++n < 50);
    if (n >= 50) mismatches++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task wait_cp();
    int n;
    n = 0;
    do @(posedge clk); while (command_out_pulse !== 1'b1 && ++n < 100);
    if (n >= 100) mismatches++;
  endtask : wait_cp

  task set_mode(input logic [1:0] m);
    logic [31:0] d;
    bus(1'b1, ADDR_CTRL, {29'h0, 1'b1, m}, 4'hf, d);
    // Receiver needs a few sync symbols to realign after a mode change
    repeat (3) wait_cp();
  endtask : set_mode

  task wait_pat(input logic [11:0] v, input int len);
    logic [11:0] msk;
    int n;
    msk = 12'hfff >> (12 - len);
    n = 0;
    while ((ser_sh & msk) !== v && n < 400) begin
      @(posedge clk);
      n++;
    end
    check(ser_sh & msk, v);
  endtask : wait_pat

  task send_word(input logic [9:0] d, input logic [3:0] c);
    int n;
    n = 0;
    @(posedge clk);
    tx_data_in <= d;
    tx_cmd_in <= c;
    input_word_strobe <= 1'b1;
    do @(posedge clk); while (tx_ack !== 1'b1 && ++n < 200);
    check(tx_ack, 1'b1);
    input_word_strobe <= 1'b0;
    n = 0;
    do @(posedge clk); while (tx_ack !== 1'b0 && ++n < 20);
  endtask : send_word

  task send_sym(input logic [9:0] v, input int cnt);
    repeat (cnt) begin
      for (int i = 9; i >= 0; i--) begin
        inject_bit <= v[i];
        @(posedge clk);
      end
    end
  endtask : send_sym

  task t_regs();
    logic [31:0] d;
    bus(1'b0, ADDR_CTRL, 32'h0, 4'hf, d);
    check(d, 32'h4);
    bus(1'b1, ADDR_CTRL, 32'h2, 4'h0, d);
    bus(1'b0, ADDR_CTRL, 32'h0, 4'hf, d);
    check(d, 32'h4);
    bus(1'b1, 4'h8, 32'hff, 4'hf, d);
    bus(1'b0, 4'h8, 32'h0, 4'hf, d);
    check(d, 32'h0);
    byte_reference_in <= 1'b1;
    repeat (5) @(posedge clk);
    check(tx_clk_out, 1'b1);
    bus(1'b1, ADDR_CTRL, 32'h0, 4'hf, d);
    repeat (5) @(posedge clk);
    check(tx_clk_out, 1'b0);
    byte_reference_in <= 1'b0;
    $display("register test ended");
  endtask : t_regs

  task t_idle();
    int n;
    for (int m = 0; m < 3; m++) begin
      set_mode(m[1:0]);
      wait_pat(sync_v[m], 10 + m);
      wait_cp();
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (command_out_pulse !== 1'b1 && n < 50);
      check(n, 10 + m);
      check(rx_cmd_out, 4'h0);
    end
    $display("idle test ended");
  endtask : t_idle

  task t_words();
    logic [31:0] keep;
    logic [31:0] got;
    logic [1:0] cur;
    int n;
    cur = 2'h3;
    for (int i = 0; i < 8; i++) begin
      if (tc[i].m !== cur) set_mode(tc[i].m);
      cur = tc[i].m;
      dq.delete();
      cq.delete();
      keep = rx_data_out;
      send_word(tc[i].d, tc[i].c);
      wait_pat(tc[i].s, 10 + tc[i].m);
      n = 0;
      while (dq.size() + cq.size() == 0 && n < 100) begin
        @(posedge clk);
        n++;
      end
      if (tc[i].c == 4'h0) begin
        got = dq.pop_front();
        check(got & (32'h3ff >> (2 - tc[i].m)), tc[i].d);
      end else begin
        got = cq.pop_front();
        check(got, tc[i].c & (4'hf >> tc[i].m));
        check(rx_data_out, keep);
      end
    end
    $display("word test ended");
  endtask : t_words

  task t_burst();
    int n;
    set_mode(2'h0);
    dq.delete();
    cq.delete();
    send_word(10'h0a5, 4'h0);
    send_word(10'h03c, 4'h0);
    send_word(10'h00f, 4'h0);
    send_word(10'h0c3, 4'h0);
    n = 0;
    while (dq.size() < 4 && n < 300) begin
      @(posedge clk);
      n++;
    end
    check({dq[0][7:0], dq[1][7:0], dq[2][7:0], dq[3][7:0]}, 32'ha53c0fc3);
    check(cq.size(), 0);
    $display("burst test ended");
  endtask : t_burst

  task t_inject();
    logic [31:0] d;
    bus(1'b1, ADDR_STATUS, 32'h10, 4'hf, d);
    inject_en <= 1'b1;
    send_sym(10'h311, 4);
    check(early_word_warning, 1'b0);
    viol_seen <= 1'b0;
    dq.delete();
    // Data words around one invalid symbol 0x210: no all-zero command is repeated on the line before the closing syncs
    send_sym(10'h2cb, 3);
    check(early_word_warning, 1'b1);
    send_sym(10'h210, 1);
    send_sym(10'h2cb, 2);
    cascade_next_byte_in <= 1'b0;
    send_sym(10'h2cb, 1);
    check(early_word_warning, 1'b0);
    cascade_next_byte_in <= 1'b1;
    send_sym(10'h311, 4);
    inject_en <= 1'b0;
    check(viol_seen, 1'b1);
    check({24'h0, dq[0][7:0]}, 32'ha5);
    bus(1'b0, ADDR_STATUS, 32'h0, 4'hf, d);
    check(d[4], 1'b1);
    repeat (4) wait_cp();
    bus(1'b1, ADDR_STATUS, 32'h10, 4'hf, d);
    bus(1'b0, ADDR_STATUS, 32'h0, 4'hf, d);
    check(d[4], 1'b0);
    $display("receive fault test ended");
  endtask : t_inject

  initial begin
    rst_n = 1'b0;
    {avs_read, avs_write, byte_reference_in, input_word_strobe} = 4'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    tx_data_in = 10'h000;
    tx_cmd_in = 4'h0;
    cascade_next_byte_in = 1'b1;
    {inject_en, inject_bit, viol_seen} = 3'h0;
    ser_sh = 12'h000;
    mismatches = 0;
    check_count = 0;
    cyc = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_idle();
    t_words();
    t_burst();
    t_inject();
    finish_test();
  end
endmodule : testbench
